// [inc/fel_defs.svh]
`ifndef FEL_DEFS_SVH
`define FEL_DEFS_SVH

// ****************************************************************
// Widths and taps
// ****************************************************************
`define FEL_LFSR_W      11
`define FEL_TAP_HI      10
`define FEL_TAP_LO      8
`define FEL_LFSR_RST    11'h000
`define FEL_SYM_W       5
`define FEL_ADDR_W      5
`define FEL_IDLE_BIT    1'h1
`define FEL_SEED_PAD    1'h1

// ****************************************************************
// Synchronisation figures
// ****************************************************************
`define FEL_SYNC_GROUPS 12
`define FEL_SYNC_BITS   (`FEL_SYNC_GROUPS * `FEL_SYM_W)
`define FEL_SYNC_CNT_W  6
`define FEL_LSM_BITS    58
`define FEL_HOLD_US     722
`define FEL_CLK_MHZ     100
`define FEL_HOLD_CYC    (`FEL_HOLD_US * `FEL_CLK_MHZ)
`define FEL_TMR_W       17

// ****************************************************************
// Line coding and buffering
// ****************************************************************
`define FEL_PHASE_POS   2'h1
`define FEL_PHASE_NEG   2'h3
`define FEL_FIFO_DEPTH  8

`endif

// [inc/fel_pkg.sv]
`include "fel_defs.svh"

package fel_pkg;

   // Two binary streams that together form the three-level line.
   typedef struct packed
   {
      logic pos;
      logic neg;
   } fel_mlt_s;

   // One received code-group with a mark for the first one after lock.
   typedef struct packed
   {
      logic                   first;
      logic [`FEL_SYM_W-1:0]  code;
   } fel_sym_s;

   typedef enum logic
   {
      FEL_HUNT,
      FEL_LOCKED
   } fel_sync_e;

   typedef logic [`FEL_LFSR_W-1:0] fel_lfsr_t;

endpackage

// [hw/fel_fifo.sv]
`timescale 1ns/1ps

module fel_fifo
   import fel_pkg::*;
#(
   parameter int WIDTH = 6,
   parameter int DEPTH = 8
)
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   // Drain side
   output logic [WIDTH-1:0]      out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] nxt_mem [DEPTH];
   logic [AW-1:0]    wr_ff;
   logic [AW-1:0]    nxt_wr;
   logic [AW-1:0]    rd_ff;
   logic [AW-1:0]    nxt_rd;
   logic [AW:0]      cnt_ff;
   logic [AW:0]      nxt_cnt;
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o  = mem_ff[rd_ff];

   always_comb
   begin
      push    = in_valid_i & in_ready_o;
      pop     = out_valid_o & out_ready_i;
      nxt_mem = mem_ff;
      nxt_wr  = wr_ff;
      nxt_rd  = rd_ff;
      nxt_cnt = cnt_ff;
      if (push)
      begin
         nxt_mem[wr_ff] = in_data_i;
         nxt_wr         = (wr_ff == AW'(DEPTH-1)) ? '0 : AW'(wr_ff + 1'b1);
      end
      if (pop)
      begin
         nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : AW'(rd_ff + 1'b1);
      end
      if (push && !pop)
      begin
         nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
      end
      else if (pop && !push)
      begin
         nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
      end
   end

   always_ff @(posedge clk_i)
   begin
      mem_ff <= nxt_mem;
      if (sys_rst_i)
      begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

endmodule

// [hw/fel_line_coding.sv]
`timescale 1ns/1ps

`include "fel_defs.svh"
module fel_line_coding
   import fel_pkg::*;
#(
   parameter int HOLD_CYC = `FEL_HOLD_CYC
)
(
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   sys_rst_i,
   // Serial NRZ code-group stream from the encoder
   input  wire logic                   tx_nrz_i,
   input  wire logic                   tx_nrz_valid_i,
   // Address strap pins
   input  wire logic [`FEL_ADDR_W-1:0] phy_address_straps_i,
   // Toward the line driver
   output fel_mlt_s                    tx_line_o,
   output logic                        tx_nrzi_o,
   // From the equaliser and analog detectors
   input  wire fel_mlt_s               rx_line_i,
   input  wire logic                   rx_energy_i,
   input  wire logic                   rx_link_pulse_i,
   output logic                        rx_signal_detect_o,
   // Received symbols toward code-group alignment
   output fel_sym_s                    rx_sym_o,
   output logic                        rx_sym_valid_o,
   input  wire logic                   rx_sym_ready_i,
   // Status
   output logic                        rx_synced_o,
   output logic                        rx_overrun_o
);

   localparam logic [`FEL_TMR_W-1:0] HOLD_LD = `FEL_TMR_W'(HOLD_CYC - 1);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Straps, energy and link-pulse flags come from pins or analog
   // comparators, so each passes two flip-flops before use.
   logic [`FEL_ADDR_W-1:0] strap_m_ff;
   logic [`FEL_ADDR_W-1:0] strap_s_ff;
   logic                   energy_m_ff;
   logic                   energy_s_ff;
   logic                   pulse_m_ff;
   logic                   pulse_s_ff;

   always_ff @(posedge clk_i)
   begin
      strap_m_ff  <= phy_address_straps_i;
      strap_s_ff  <= strap_m_ff;
      energy_m_ff <= rx_energy_i;
      energy_s_ff <= energy_m_ff;
      pulse_m_ff  <= rx_link_pulse_i;
      pulse_s_ff  <= pulse_m_ff;
   end

   // ****************************************************************
   // Transmit path
   // ****************************************************************
   fel_lfsr_t  tx_lfsr_ff;
   fel_lfsr_t  nxt_tx_lfsr;
   logic       tx_seeded_ff;
   logic       nxt_tx_seeded;
   logic       tx_nrzi_ff;
   logic       nxt_tx_nrzi;
   logic [1:0] tx_phase_ff;
   logic [1:0] nxt_tx_phase;
   fel_mlt_s   tx_line_ff;
   fel_mlt_s   nxt_tx_line;
   logic       tx_key;
   logic       tx_src;
   logic       tx_scr;
   fel_lfsr_t  tx_seed;

   always_comb
   begin
      tx_seed     = {strap_s_ff, ~strap_s_ff, `FEL_SEED_PAD};
      tx_key      = tx_lfsr_ff[`FEL_TAP_HI] ^ tx_lfsr_ff[`FEL_TAP_LO];
      // Idle ones fill every gap so the far end can keep its lock.
      tx_src      = tx_nrz_valid_i ? tx_nrz_i : `FEL_IDLE_BIT;
      tx_scr      = tx_src ^ tx_key;
      // The seed is taken one cycle after reset releases, once the
      // strap synchroniser holds settled values.
      nxt_tx_seeded = 1'b1;
      nxt_tx_lfsr   = tx_seeded_ff ? {tx_lfsr_ff[`FEL_TAP_HI-1:0], tx_key}
                                   : tx_seed;
      nxt_tx_nrzi   = tx_nrzi_ff ^ tx_scr;
      // Each one event steps the phase through pos, zero, neg, zero, so the
      // non-zero levels alternate between the positive and the negative stream.
      nxt_tx_phase  = tx_phase_ff + {1'b0, tx_scr};
      nxt_tx_line.pos = (nxt_tx_phase == `FEL_PHASE_POS);
      nxt_tx_line.neg = (nxt_tx_phase == `FEL_PHASE_NEG);
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         tx_lfsr_ff   <= `FEL_LFSR_RST;
         tx_seeded_ff <= 1'b0;
         tx_nrzi_ff   <= 1'b0;
         tx_phase_ff  <= 2'h0;
         tx_line_ff   <= '0;
      end
      else
      begin
         tx_lfsr_ff   <= nxt_tx_lfsr;
         tx_seeded_ff <= nxt_tx_seeded;
         tx_nrzi_ff   <= nxt_tx_nrzi;
         tx_phase_ff  <= nxt_tx_phase;
         tx_line_ff   <= nxt_tx_line;
      end
   end

   // The three-level pair and the NRZI stream leave the block; there is no path that
   // puts plain binary data on the transmit pair.
   assign tx_line_o = tx_line_ff;
   assign tx_nrzi_o = tx_nrzi_ff;

   // ****************************************************************
   // Receive line decoding
   // ****************************************************************
   fel_mlt_s rx_prev_ff;
   logic     rx_nrzi_ff;
   logic     rx_nrzi_d_ff;
   logic     rx_sd_ff;
   logic     nxt_rx_nrzi;
   logic     rx_sd;

   always_comb
   begin
      // Any change of the three-level state is one NRZI transition.
      nxt_rx_nrzi = rx_nrzi_ff ^ (rx_line_i != rx_prev_ff);
      rx_sd       = rx_nrzi_ff ^ rx_nrzi_d_ff;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         rx_prev_ff   <= '0;
         rx_nrzi_ff   <= 1'b0;
         rx_nrzi_d_ff <= 1'b0;
         rx_sd_ff     <= 1'b0;
         rx_signal_detect_o <= 1'b0;
      end
      else
      begin
         rx_prev_ff   <= rx_line_i;
         rx_nrzi_ff   <= nxt_rx_nrzi;
         rx_nrzi_d_ff <= rx_nrzi_ff;
         rx_sd_ff     <= rx_sd;
         // Link pulse activity vetoes the energy detector.
         rx_signal_detect_o <= energy_s_ff & ~pulse_s_ff;
      end
   end

   // ****************************************************************
   // Descrambler, line-state monitor and hold timer
   // ****************************************************************
   fel_sync_e                 sync_ff;
   fel_sync_e                 nxt_sync;
   fel_lfsr_t                 rx_lfsr_ff;
   fel_lfsr_t                 nxt_rx_lfsr;
   logic [`FEL_SYNC_CNT_W-1:0] hunt_cnt_ff;
   logic [`FEL_SYNC_CNT_W-1:0] nxt_hunt_cnt;
   logic [`FEL_SYNC_CNT_W-1:0] ones_cnt_ff;
   logic [`FEL_SYNC_CNT_W-1:0] nxt_ones_cnt;
   logic [`FEL_TMR_W-1:0]     hold_ff;
   logic [`FEL_TMR_W-1:0]     nxt_hold;
   logic                      rx_key;
   logic                      rx_ud;
   logic                      bit_ok;
   logic                      lock_now;

   always_comb
   begin
      rx_key       = rx_lfsr_ff[`FEL_TAP_HI] ^ rx_lfsr_ff[`FEL_TAP_LO];
      rx_ud        = rx_sd_ff ^ rx_key;
      bit_ok       = 1'b0;
      lock_now     = 1'b0;
      nxt_sync     = sync_ff;
      nxt_rx_lfsr  = rx_lfsr_ff;
      nxt_hunt_cnt = hunt_cnt_ff;
      nxt_ones_cnt = ones_cnt_ff;
      nxt_hold     = hold_ff;
      unique case (sync_ff)
         FEL_HUNT:
         begin
            // During idle the key equals the inverted line bit, so the
            // register is loaded straight from the line. A run of
            // correct predictions then proves the key is tracked.
            nxt_rx_lfsr = {rx_lfsr_ff[`FEL_TAP_HI-1:0], ~rx_sd_ff};
            bit_ok      = (~rx_sd_ff == rx_key);
            nxt_hunt_cnt = bit_ok ? `FEL_SYNC_CNT_W'(hunt_cnt_ff + 1'b1) : '0;
            if (bit_ok && (hunt_cnt_ff == `FEL_SYNC_CNT_W'(`FEL_SYNC_BITS - 1)))
            begin
               lock_now     = 1'b1;
               nxt_sync     = FEL_LOCKED;
               nxt_hunt_cnt = '0;
               nxt_ones_cnt = '0;
               nxt_hold     = HOLD_LD;
            end
         end
         FEL_LOCKED:
         begin
            nxt_rx_lfsr  = {rx_lfsr_ff[`FEL_TAP_HI-1:0], rx_key};
            nxt_ones_cnt = rx_ud ? `FEL_SYNC_CNT_W'(ones_cnt_ff + 1'b1) : '0;
            nxt_hold     = `FEL_TMR_W'(hold_ff - 1'b1);
            if (rx_ud && (ones_cnt_ff == `FEL_SYNC_CNT_W'(`FEL_LSM_BITS - 1)))
            begin
               nxt_ones_cnt = '0;
               nxt_hold     = HOLD_LD;
            end
            else if (hold_ff == '0)
            begin
               // Restart: key, ones counter and deserialiser count clear; the hold timer wraps to all ones.
               nxt_sync     = FEL_HUNT;
               nxt_rx_lfsr  = `FEL_LFSR_RST;
               nxt_ones_cnt = '0;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         sync_ff     <= FEL_HUNT;
         rx_lfsr_ff  <= `FEL_LFSR_RST;
         hunt_cnt_ff <= '0;
         ones_cnt_ff <= '0;
         hold_ff     <= '0;
      end
      else
      begin
         sync_ff     <= nxt_sync;
         rx_lfsr_ff  <= nxt_rx_lfsr;
         hunt_cnt_ff <= nxt_hunt_cnt;
         ones_cnt_ff <= nxt_ones_cnt;
         hold_ff     <= nxt_hold;
      end
   end

   // ****************************************************************
   // Serial to parallel
   // ****************************************************************
   // Groups are unaligned: counting starts at the lock point. The line
   // cannot be stalled, so a group meeting a full buffer is dropped and
   // the overrun flag records it until the next lock.
   logic [`FEL_SYM_W-1:0] shift_ff;
   logic [`FEL_SYM_W-1:0] nxt_shift;
   logic [2:0]            bit_cnt_ff;
   logic [2:0]            nxt_bit_cnt;
   logic                  first_ff;
   logic                  nxt_first;
   logic                  overrun_ff;
   logic                  nxt_overrun;
   logic                  push;
   logic                  fifo_ready;
   fel_sym_s              push_sym;

   always_comb
   begin
      nxt_shift   = {shift_ff[`FEL_SYM_W-2:0], rx_ud};
      nxt_bit_cnt = bit_cnt_ff;
      nxt_first   = first_ff;
      nxt_overrun = overrun_ff;
      push        = 1'b0;
      push_sym.first = first_ff;
      push_sym.code  = nxt_shift;
      if (sync_ff != FEL_LOCKED || nxt_sync != FEL_LOCKED)
      begin
         // Nothing is handed on outside lock.
         nxt_bit_cnt = '0;
         nxt_first   = 1'b1;
      end
      else if (bit_cnt_ff == 3'(`FEL_SYM_W - 1))
      begin
         push        = 1'b1;
         nxt_bit_cnt = '0;
         nxt_first   = 1'b0;
      end
      else
      begin
         nxt_bit_cnt = 3'(bit_cnt_ff + 1'b1);
      end
      if (lock_now)
      begin
         nxt_overrun = 1'b0;
      end
      if (push && !fifo_ready)
      begin
         nxt_overrun = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         shift_ff   <= '0;
         bit_cnt_ff <= '0;
         first_ff   <= 1'b1;
         overrun_ff <= 1'b0;
      end
      else
      begin
         shift_ff   <= nxt_shift;
         bit_cnt_ff <= nxt_bit_cnt;
         first_ff   <= nxt_first;
         overrun_ff <= nxt_overrun;
      end
   end

   fel_fifo
   #(
      .WIDTH ($bits(fel_sym_s)),
      .DEPTH (`FEL_FIFO_DEPTH)
   )
   u_sym_fifo
   (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_data_i   (push_sym),
      .in_valid_i  (push),
      .in_ready_o  (fifo_ready),
      .out_data_o  (rx_sym_o),
      .out_valid_o (rx_sym_valid_o),
      .out_ready_i (rx_sym_ready_i)
   );

   assign rx_synced_o  = (sync_ff == FEL_LOCKED);
   assign rx_overrun_o = overrun_ff;

endmodule

// [tb/fel_partner.sv]
`timescale 1ns/1ps

module fel_partner
   import fel_pkg::*;
#(
   parameter fel_lfsr_t SEED = 11'h5A3
)
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   // Unscrambled bit of the far encoder
   input  wire logic bit_i,
   input  wire logic valid_i,
   // Three-level line toward the receiver
   output fel_mlt_s  line_o
);
   fel_lfsr_t  lfsr_ff;
   fel_lfsr_t  nxt_lfsr;
   logic [1:0] phase_ff;
   logic [1:0] nxt_phase;
   logic       key;
   logic       scr;

   // ****************************************************************
   // Far-end scrambler and three-level coder
   // ****************************************************************
   always_comb
   begin
      key       = lfsr_ff[10] ^ lfsr_ff[8];
      scr       = (valid_i ? bit_i : 1'h1) ^ key;
      nxt_lfsr  = {lfsr_ff[9:0], key};
      nxt_phase = phase_ff + {1'h0, scr};
   end

   always_ff @(posedge clk_i)
   begin
      lfsr_ff  <= sys_rst_i ? SEED : nxt_lfsr;
      phase_ff <= sys_rst_i ? 2'h0 : nxt_phase;
   end

   assign line_o = '{pos: phase_ff == 2'h1, neg: phase_ff == 2'h3};
endmodule

// [tb/fel_line_coding_chk.sv]
`timescale 1ns/1ps

module fel_line_coding_chk
   import fel_pkg::*;
#(
   parameter int HOLD_CYC = 200
)
(
   // Clock and reset
   input  wire logic     clk_i,
   input  wire logic     sys_rst_i,
   // Watched ports
   input  wire fel_mlt_s tx_line_o,
   input  wire logic     tx_nrzi_o,
   input  wire logic     rx_link_pulse_i,
   input  wire logic     rx_signal_detect_o,
   input  wire fel_sym_s rx_sym_o,
   input  wire logic     rx_sym_valid_o,
   input  wire logic     rx_sym_ready_i,
   input  wire logic     rx_synced_o,
   input  wire logic     rx_overrun_o
);
   logic        last_neg_ff;
   logic        nxt_last_neg;
   logic [16:0] lock_cyc_ff;
   logic [16:0] nxt_lock_cyc;

   // ****************************************************************
   // Which rail carried the last one event
   // ****************************************************************
   always_comb
   begin
      nxt_last_neg = last_neg_ff;
      if (tx_line_o.neg)
         nxt_last_neg = 1'h1;
      if (tx_line_o.pos)
         nxt_last_neg = 1'h0;
   end

   always_ff @(posedge clk_i)
   begin
      last_neg_ff <= sys_rst_i ? 1'h1 : nxt_last_neg;
   end

   // ****************************************************************
   // Cycles spent in lock, saturating
   // ****************************************************************
   always_comb
   begin
      nxt_lock_cyc = '0;
      if (rx_synced_o && lock_cyc_ff != '1)
         nxt_lock_cyc = 17'(lock_cyc_ff + 1'b1);
      else if (rx_synced_o)
         nxt_lock_cyc = lock_cyc_ff;
   end

   always_ff @(posedge clk_i)
   begin
      lock_cyc_ff <= sys_rst_i ? '0 : nxt_lock_cyc;
   end

   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_nrzi_line_agree: assert property ($changed(tx_nrzi_o) == $changed(tx_line_o))
      else $error("line and nrzi disagree");
   a_pos_after_neg: assert property ($rose(tx_line_o.pos) |-> last_neg_ff)
      else $error("pos rail repeated");
   a_neg_after_pos: assert property ($rose(tx_line_o.neg) |-> !last_neg_ff)
      else $error("neg rail repeated");
   a_three_level: assert property (!(tx_line_o.pos && tx_line_o.neg))
      else $error("both rails driven");
   a_pulse_veto: assert property (rx_link_pulse_i [*4] |-> !rx_signal_detect_o)
      else $error("detect during link pulses");
   a_push_when_locked: assert property ($rose(rx_sym_valid_o) |-> $past(rx_synced_o))
      else $error("symbol pushed out of lock");
   a_no_push_hunt: assert property (!rx_synced_o && !rx_sym_valid_o |=> !rx_sym_valid_o)
      else $error("symbol appeared in hunt");
   a_symbol_holds: assert property (rx_sym_valid_o && !rx_sym_ready_i
      |=> rx_sym_valid_o && $stable(rx_sym_o))
      else $error("symbol changed while stalled");
   a_overrun_sticky: assert property (rx_overrun_o |=> rx_overrun_o || $rose(rx_synced_o))
      else $error("overrun cleared early");
   a_hold_min: assert property ($fell(rx_synced_o) |-> lock_cyc_ff >= 17'(HOLD_CYC))
      else $error("lock lost before hold period");

   c_lock: cover property ($rose(rx_synced_o));
   c_unlock: cover property ($fell(rx_synced_o));
   c_overrun: cover property ($rose(rx_overrun_o));
endmodule

bind fel_line_coding fel_line_coding_chk #(.HOLD_CYC(HOLD_CYC)) fel_line_coding_chk_inst (
   .clk_i, .sys_rst_i, .tx_line_o, .tx_nrzi_o, .rx_link_pulse_i, .rx_signal_detect_o,
   .rx_sym_o, .rx_sym_valid_o, .rx_sym_ready_i, .rx_synced_o, .rx_overrun_o);

// [tb/fel_line_coding_bench.sv]
`timescale 1ns/1ps

module fel_line_coding_bench
   import fel_pkg::*;
;
   localparam int HOLD = 200;
   logic       clk_i = 1'h0;
   logic       sys_rst_i = 1'h1;
   logic       tx_nrz_i = 1'h0;
   logic       tx_valid = 1'h0;
   logic [4:0] straps = 5'h00;
   logic       energy = 1'h0;
   logic       pulse = 1'h0;
   logic       ready = 1'h1;
   logic       p_bit = 1'h1;
   logic       p_valid = 1'h0;
   fel_mlt_s   tx_line;
   fel_mlt_s   rx_line;
   fel_sym_s   sym;
   logic       nrzi, detect, sym_valid, synced, overrun;
   logic       sym_chk = 1'h1, fp = 1'h0, sy_q = 1'h0, started = 1'h0, seeded, b, k, ex_nrzi;
   logic [1:0] ph;
   fel_lfsr_t  lf;
   int         failures = 0, n_tests = 0, cyc = 0, npop = 0, nzero = 0;

   always #5 clk_i = ~clk_i;

   fel_partner fel_partner_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bit_i(p_bit),
      .valid_i(p_valid), .line_o(rx_line));

   fel_line_coding #(.HOLD_CYC(HOLD)) fel_line_coding_inst (.clk_i(clk_i),
      .sys_rst_i(sys_rst_i), .tx_nrz_i(tx_nrz_i), .tx_nrz_valid_i(tx_valid),
      .phy_address_straps_i(straps), .tx_line_o(tx_line), .tx_nrzi_o(nrzi),
      .rx_line_i(rx_line), .rx_energy_i(energy), .rx_link_pulse_i(pulse),
      .rx_signal_detect_o(detect), .rx_sym_o(sym), .rx_sym_valid_o(sym_valid),
      .rx_sym_ready_i(ready), .rx_synced_o(synced), .rx_overrun_o(overrun));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wait_sync(input int lim);
      for (int i = 0; i < lim && synced !== 1'h1; i++)
         @(posedge clk_i);
   endtask

   task automatic look(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   // ****************************************************************
   // Transmit model, random source and watchdog
   // ****************************************************************
   always @(posedge clk_i)
   begin
      started = 1'h1;
      if (sys_rst_i)
      begin
         lf = '0;
         ph = 2'h0;
         ex_nrzi = 1'h0;
         seeded = 1'h0;
      end
      else
      begin
         b = tx_valid ? tx_nrz_i : 1'h1;
         k = lf[10] ^ lf[8];
         ex_nrzi = ex_nrzi ^ b ^ k;
         ph = ph + {1'h0, b ^ k};
         lf = seeded ? {lf[9:0], k} : {straps, ~straps, 1'h1};
         seeded = 1'h1;
      end
      tx_nrz_i <= 1'($urandom);
      tx_valid <= 1'($urandom);
      cyc++;
      if (cyc > 6000)
      begin
         failures++;
         summarize();
      end
   end

   // ****************************************************************
   // Result comparisons at the settled half of the cycle
   // ****************************************************************
   always @(negedge clk_i)
   begin
      if (synced === 1'h1 && sy_q !== 1'h1)
         fp = 1'h1;
      sy_q = synced;
      if (sym_valid === 1'h1 && ready === 1'h1 && sys_rst_i === 1'h0)
      begin
         npop++;
         nzero += 5 - $countones(sym.code);
         chk("first", {7'h00, fp}, {7'h00, sym.first});
         fp = 1'h0;
         if (sym_chk)
            chk("symbol", 8'h1F, {3'h0, sym.code});
      end
      if (started)
      begin
         chk("tx_nrzi", {7'h00, ex_nrzi}, {7'h00, nrzi});
         chk("tx_line", {6'h00, ph == 2'h1, ph == 2'h3}, {6'h00, tx_line});
      end
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial
   begin
      void'($urandom(79));
      straps <= 5'($urandom);
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_i);
         energy <= i[0];
         pulse <= i[1];
         look(6);
         chk("detect", {7'h00, i[0] & ~i[1]}, {7'h00, detect});
      end
      @(posedge clk_i);
      energy <= 1'h1;
      pulse <= 1'h0;
      wait_sync(300);
      look(1);
      chk("lock", 8'h01, {7'h00, synced});
      look(3 * HOLD);
      chk("held", 8'h01, {7'h00, synced});
      // Three zeros inside the idles must come back as exactly three zeros.
      @(posedge clk_i);
      sym_chk <= 1'h0;
      nzero = 0;
      p_valid <= 1'h1;
      p_bit <= 1'h0;
      repeat (3) @(posedge clk_i);
      p_valid <= 1'h0;
      look(60);
      chk("zeros", 8'h03, nzero[7:0]);
      // Stall the consumer and starve the monitor of idles.
      @(posedge clk_i);
      ready <= 1'h0;
      npop = 0;
      p_valid <= 1'h1;
      look(HOLD - 70);
      chk("still", 8'h01, {7'h00, synced});
      look(100);
      chk("dropped", 8'h00, {7'h00, synced});
      chk("overrun", 8'h01, {7'h00, overrun});
      @(posedge clk_i);
      ready <= 1'h1;
      look(20);
      chk("depth", 8'h08, npop[7:0]);
      chk("empty", 8'h00, {7'h00, sym_valid});
      @(posedge clk_i);
      p_valid <= 1'h0;
      sym_chk <= 1'h1;
      wait_sync(300);
      look(20);
      chk("relock", 8'h01, {7'h00, synced});
      chk("ovr_clear", 8'h00, {7'h00, overrun});
      // A second reset with other straps must reseed the scrambler.
      @(posedge clk_i);
      sys_rst_i <= 1'h1;
      straps <= ~straps;
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      look(100);
      summarize();
   end
endmodule
